// ===== hw/swd_map.svh
`ifndef SWD_MAP_SVH
`define SWD_MAP_SVH

// core clock, also the internal oscillator time base
`define SWD_CLK_HZ 100000000
`define SWD_TICKS_PER_MS (`SWD_CLK_HZ / 1000)

// internal oscillator periods, in milliseconds
`define SWD_T_RESET_MS 200
`define SWD_T_WD_LONG_MS 1600
`define SWD_T_WD_SHORT_MS 100

// external clock / capacitor oscillator periods, in oscillator ticks
`define SWD_EXT_WD_TICKS 1024
`define SWD_EXT_WD_FIRST_TICKS 4096
`define SWD_EXT_RESET_TICKS 2048

// counter width, wide enough for the longest internal period
`define SWD_CNT_W 32

// reset values of the outputs
`define SWD_RST_RESET_N 1'h0
`define SWD_RST_WDO_N 1'h1

`endif

// ===== hw/swd_pkg.sv
package swd_pkg;

	// core sequencing states
	typedef enum logic [0:0] {
		SWD_ST_RESET,
		SWD_ST_WATCH
	} swd_state_t;

	// timing source decoded from the three configuration inputs
	typedef enum logic [1:0] {
		SWD_MODE_INT_LONG,
		SWD_MODE_INT_SHORT,
		SWD_MODE_EXT_CLK,
		SWD_MODE_EXT_CAP
	} swd_mode_t;

	// synchroniser state: first and second stage of three flags
	typedef struct packed {
		logic [2:0] stage1;
		logic [2:0] stage2;
	} swd_sync_state_t;

	// tick generator state
	typedef struct packed {
		logic ext_clk_prev;
	} swd_tick_state_t;

	// core watchdog state
	typedef struct packed {
		swd_state_t state;
		logic [31:0] count;
		logic first_period;
		logic wdo_n;
		logic reset_n;
		logic kick_prev;
		logic ce_gate;
		logic pf_flag_n;
		logic batt_sel;
	} swd_core_state_t;

endpackage : swd_pkg

// ===== hw/swd_sync.sv
`timescale 1ns/1ps
`include "swd_map.svh"

// two-flop synchroniser for the analog comparator flags
module swd_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] flags_in,
	output logic [2:0] flags_out
);
	import swd_pkg::*;

	swd_sync_state_t cur;
	swd_sync_state_t next_cur;

	// stage1 is only ever read by stage2
	always_comb begin
		next_cur = cur;
		next_cur.stage1 = flags_in;
		next_cur.stage2 = cur.stage1;
	end

	// reset to "supply bad, no fault": safest view until the flags settle
	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign flags_out = cur.stage2;
endmodule : swd_sync

// ===== hw/swd_tick.sv
`timescale 1ns/1ps
`include "swd_map.svh"

// picks the tick source and period lengths for the selected mode
module swd_tick #(
	parameter logic [31:0] RESET_CYC = 32'h0,
	parameter logic [31:0] WD_LONG_CYC = 32'h0,
	parameter logic [31:0] WD_SHORT_CYC = 32'h0
) (
	input wire logic clk,
	input wire logic rst,
	input swd_pkg::swd_mode_t mode,
	input wire logic osc_timing_in,
	input wire logic cap_osc_tick,
	output logic tick,
	output logic [31:0] lim_normal,
	output logic [31:0] lim_first,
	output logic [31:0] lim_reset
);
	import swd_pkg::*;

	swd_tick_state_t cur;
	swd_tick_state_t next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.ext_clk_prev = osc_timing_in;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// internal mode counts core clocks; external modes count oscillator ticks
	always_comb begin
		unique case (mode)
			SWD_MODE_INT_LONG: begin
				tick = 1'h1;
				lim_normal = WD_LONG_CYC;
				lim_first = WD_LONG_CYC;
				lim_reset = RESET_CYC;
			end
			SWD_MODE_INT_SHORT: begin
				tick = 1'h1;
				lim_normal = WD_SHORT_CYC;
				lim_first = WD_LONG_CYC;
				lim_reset = RESET_CYC;
			end
			SWD_MODE_EXT_CLK: begin
				tick = osc_timing_in & ~cur.ext_clk_prev; // rising edge of external clock
				lim_normal = 32'(`SWD_EXT_WD_TICKS);
				lim_first = 32'(`SWD_EXT_WD_FIRST_TICKS);
				lim_reset = 32'(`SWD_EXT_RESET_TICKS);
			end
			SWD_MODE_EXT_CAP: begin
				// cap oscillator period is scaled so 600:2400:1200 ms maps to these counts
				tick = cap_osc_tick;
				lim_normal = 32'(`SWD_EXT_WD_TICKS);
				lim_first = 32'(`SWD_EXT_WD_FIRST_TICKS);
				lim_reset = 32'(`SWD_EXT_RESET_TICKS);
			end
		endcase
	end
endmodule : swd_tick

// ===== hw/swd_core.sv
`timescale 1ns/1ps
`include "swd_map.svh"

module swd_core #(
	parameter logic [31:0] RESET_CYC = 32'(`SWD_T_RESET_MS * `SWD_TICKS_PER_MS),
	parameter logic [31:0] WD_LONG_CYC = 32'(`SWD_T_WD_LONG_MS * `SWD_TICKS_PER_MS),
	parameter logic [31:0] WD_SHORT_CYC = 32'(`SWD_T_WD_SHORT_MS * `SWD_TICKS_PER_MS)
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic SUPPLY_VALID,
	input wire logic VCC_BELOW_BATT,
	input wire logic POWER_FAIL_SENSE_LOW,
	input wire logic OSC_SOURCE_SELECT,
	input wire logic OSC_TIMING_IN,
	input wire logic OSC_CAP_PRESENT,
	input wire logic CAP_OSC_TICK,
	input wire logic WATCHDOG_KICK_IN,
	input wire logic CE_IN_N,
	output logic CE_OUT_N,
	output logic WATCHDOG_FLAG_N,
	output logic RESET_N,
	output logic RESET,
	output logic POWER_FAIL_FLAG_N,
	output logic BACKUP_SUPPLY_SELECT,
	output logic KICK_BIAS_EN
);
	import swd_pkg::*;

	swd_core_state_t cur;
	swd_core_state_t next_cur;
	logic [2:0] flags_sync;
	logic supply_ok;
	logic below_batt;
	logic pf_low;
	swd_mode_t mode;
	logic tick;
	logic [31:0] lim_normal;
	logic [31:0] lim_first;
	logic [31:0] lim_reset;
	logic [31:0] lim_watch;
	logic kick_edge;
	logic [31:0] count_inc;

	// comparator flags cross in from the analog side
	swd_sync u_sync (
		.clk(CLK),
		.rst(SYS_RST),
		.flags_in({POWER_FAIL_SENSE_LOW, VCC_BELOW_BATT, SUPPLY_VALID}),
		.flags_out(flags_sync)
	);

	assign supply_ok = flags_sync[0];
	assign below_batt = flags_sync[1];
	assign pf_low = flags_sync[2];

	// decode the configuration inputs into a timing mode
	always_comb begin
		if (OSC_SOURCE_SELECT) begin
			mode = OSC_TIMING_IN ? SWD_MODE_INT_LONG : SWD_MODE_INT_SHORT;
		end else begin
			mode = OSC_CAP_PRESENT ? SWD_MODE_EXT_CAP : SWD_MODE_EXT_CLK;
		end
	end

	swd_tick #(
		.RESET_CYC(RESET_CYC),
		.WD_LONG_CYC(WD_LONG_CYC),
		.WD_SHORT_CYC(WD_SHORT_CYC)
	) u_tick (
		.clk(CLK),
		.rst(SYS_RST),
		.mode(mode),
		.osc_timing_in(OSC_TIMING_IN),
		.cap_osc_tick(CAP_OSC_TICK),
		.tick(tick),
		.lim_normal(lim_normal),
		.lim_first(lim_first),
		.lim_reset(lim_reset)
	);

	// either polarity counts as a kick
	assign kick_edge = WATCHDOG_KICK_IN ^ cur.kick_prev;
	assign count_inc = cur.count + 32'h1;
	// long period holds until the first kick after reset
	assign lim_watch = cur.first_period ? lim_first : lim_normal;

	// watchdog and reset sequencing
	always_comb begin
		next_cur = cur;
		next_cur.kick_prev = WATCHDOG_KICK_IN;
		next_cur.ce_gate = supply_ok;
		next_cur.pf_flag_n = ~pf_low;
		next_cur.batt_sel = below_batt & ~supply_ok;
		if (!supply_ok) begin
			// watchdog off, reset held, period restarts once supply recovers
			next_cur.state = SWD_ST_RESET;
			next_cur.count = 32'h0;
			next_cur.reset_n = 1'h0;
			next_cur.wdo_n = 1'h1;
			next_cur.first_period = 1'h1;
		end else begin
			if (kick_edge) begin
				next_cur.wdo_n = 1'h1;
			end
			unique case (cur.state)
				SWD_ST_RESET: begin
					next_cur.reset_n = 1'h0;
					if (tick) begin
						if (count_inc >= lim_reset) begin
							// pulse over: fresh long watchdog period
							next_cur.state = SWD_ST_WATCH;
							next_cur.count = 32'h0;
							next_cur.reset_n = 1'h1;
							next_cur.first_period = 1'h1;
						end else begin
							next_cur.count = count_inc;
						end
					end
				end
				SWD_ST_WATCH: begin
					next_cur.reset_n = 1'h1;
					if (kick_edge) begin
						next_cur.count = 32'h0;
						next_cur.first_period = 1'h0;
					end else if (tick) begin
						if (count_inc >= lim_watch) begin
							// timeout: flag low and start a reset pulse
							next_cur.wdo_n = 1'h0;
							next_cur.state = SWD_ST_RESET;
							next_cur.reset_n = 1'h0;
							next_cur.count = 32'h0;
						end else begin
							next_cur.count = count_inc;
						end
					end
				end
			endcase
		end
	end

	// reset puts the part in its power-up view: reset asserted, memory gated
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cur.state <= SWD_ST_RESET;
			cur.count <= 32'h0;
			cur.first_period <= 1'h1;
			cur.wdo_n <= `SWD_RST_WDO_N;
			cur.reset_n <= `SWD_RST_RESET_N;
			cur.kick_prev <= 1'h0;
			cur.ce_gate <= 1'h0;
			cur.pf_flag_n <= 1'h1;
			cur.batt_sel <= 1'h0;
		end else begin
			cur <= next_cur;
		end
	end

	// gate is combinational so chip-enable sees no added clock latency
	assign CE_OUT_N = cur.ce_gate ? CE_IN_N : 1'h1;
	assign WATCHDOG_FLAG_N = cur.wdo_n;
	assign RESET_N = cur.reset_n;
	assign RESET = ~cur.reset_n;
	assign POWER_FAIL_FLAG_N = cur.pf_flag_n;
	assign BACKUP_SUPPLY_SELECT = cur.batt_sel;
	assign KICK_BIAS_EN = cur.ce_gate;
endmodule : swd_core

// ===== verification/swd_checker.sv
`timescale 1ns/1ps
// output relations of the supervisor core
module swd_checker #(
	parameter logic [31:0] RESET_CYC = 32'h0
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic SUPPLY_VALID,
	input wire logic VCC_BELOW_BATT,
	input wire logic POWER_FAIL_SENSE_LOW,
	input wire logic WATCHDOG_KICK_IN,
	input wire logic CE_IN_N,
	input wire logic CE_OUT_N,
	input wire logic WATCHDOG_FLAG_N,
	input wire logic RESET_N,
	input wire logic RESET,
	input wire logic POWER_FAIL_FLAG_N,
	input wire logic BACKUP_SUPPLY_SELECT,
	input wire logic KICK_BIAS_EN
);
	logic [31:0] low_cnt;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	// pulse length so far; supply loss only lengthens it
	always_ff @(posedge CLK) begin
		if (SYS_RST || RESET_N)
			low_cnt <= 32'h0;
		else
			low_cnt <= low_cnt + 32'h1;
	end
	out_compl_a: assert property (RESET == !RESET_N)
		else $error("reset pair mismatch");
	// supply input held past the sync and state latency, so the gate is judged against the pin
	ce_block_a: assert property (!SUPPLY_VALID [*5] |-> CE_OUT_N)
		else $error("ce not blocked");
	ce_pass_a: assert property (SUPPLY_VALID [*5] |-> CE_OUT_N == CE_IN_N)
		else $error("ce not passed");
	flag_supply_a: assert property (!SUPPLY_VALID [*5] |-> WATCHDOG_FLAG_N && !RESET_N)
		else $error("flag or reset wrong in supply loss");
	supply_drop_a: assert property ($fell(SUPPLY_VALID) |-> ##[1:4] !KICK_BIAS_EN)
		else $error("watchdog not disabled");
	kick_clear_a: assert property (!WATCHDOG_FLAG_N && $changed(WATCHDOG_KICK_IN) |=> WATCHDOG_FLAG_N)
		else $error("kick did not raise flag");
	pulse_len_a: assert property ($rose(RESET_N) |-> low_cnt >= RESET_CYC - 32'h2)
		else $error("reset pulse short");
	pf_flag_a: assert property (POWER_FAIL_SENSE_LOW [*5] |-> !POWER_FAIL_FLAG_N)
		else $error("power-fail flag high");
	batt_on_a: assert property ((VCC_BELOW_BATT && !SUPPLY_VALID) [*5] |-> BACKUP_SUPPLY_SELECT)
		else $error("battery not selected");
	cover property ($fell(WATCHDOG_FLAG_N));
	cover property ($rose(RESET_N));
	cover property (BACKUP_SUPPLY_SELECT);
endmodule : swd_checker

// ===== verification/swd_host.sv
`timescale 1ns/1ps
// host: toggles kick every gap+1 cycles while enabled; ram select toggles each cycle
module swd_host (
	input wire logic clk,
	input wire logic en,
	input wire logic [15:0] gap,
	output logic kick,
	output logic ce_n
);
	logic [15:0] cnt = 16'h0;
	initial kick = 1'h0;
	initial ce_n = 1'h1;
	// gap below the short period keeps the watchdog quiet
	always @(posedge clk) begin
		ce_n <= ~ce_n;
		cnt <= (en && cnt < gap) ? cnt + 16'h1 : 16'h0;
		if (en && cnt == gap)
			kick <= ~kick;
	end
endmodule : swd_host

// ===== verification/swd_core_tb.sv
`timescale 1ns/1ps
module swd_core_tb;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic sv = 1'h1;
	logic vbb = 1'h0;
	logic pfs = 1'h0;
	logic sel = 1'h1;
	logic tim = 1'h1;
	logic capm = 1'h0;
	logic ctk = 1'h0;
	logic ext = 1'h0;
	logic en = 1'h0;
	logic [15:0] gap = 16'h0;
	logic kick, ce_in_n, ce_out_n, wdo_n, rst_n, rst_hi, pf_n, batt, bias;
	int num_errors = 0;
	int tests_run = 0;
	int n;
	always #5 clk = ~clk;
	// external clock and capacitor ticks, one tick every second cycle
	always @(posedge clk) begin
		if (ext)
			tim <= ~tim;
		ctk <= capm & ~ctk;
	end
	swd_host host (.clk(clk), .en(en), .gap(gap), .kick(kick), .ce_n(ce_in_n));
	swd_core #(.RESET_CYC(32'hC8), .WD_LONG_CYC(32'h640), .WD_SHORT_CYC(32'h64)) dut (.CLK(clk), .SYS_RST(rst),
		.SUPPLY_VALID(sv), .VCC_BELOW_BATT(vbb), .POWER_FAIL_SENSE_LOW(pfs), .OSC_SOURCE_SELECT(sel),
		.OSC_TIMING_IN(tim), .OSC_CAP_PRESENT(capm), .CAP_OSC_TICK(ctk), .WATCHDOG_KICK_IN(kick),
		.CE_IN_N(ce_in_n), .CE_OUT_N(ce_out_n), .WATCHDOG_FLAG_N(wdo_n), .RESET_N(rst_n), .RESET(rst_hi),
		.POWER_FAIL_FLAG_N(pf_n), .BACKUP_SUPPLY_SELECT(batt), .KICK_BIAS_EN(bias));
	task final_report;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task chk(input bit ok, input string m);
		tests_run++;
		if (!ok) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	// bounded wait for the reset output to reach v, cycles left in n
	task wt(input logic v, input int lim);
		n = 0;
		while (rst_n !== v) begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim) begin
				num_errors++;
				$display("[FAIL] %0t wait for reset level timed out", $time);
				final_report();
			end
		end
	endtask : wt
	// latency of synchroniser and tick edge allowed above the count
	function bit near(input int x);
		return n >= x - 4 && n <= x + 8;
	endfunction : near
	task start(input logic s, t, c, e, input int r);
		@(posedge clk);
		rst <= 1'h1;
		sel <= s;
		tim <= t;
		capm <= c;
		ext <= e;
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		wt(1'h1, r + 32);
		chk(near(r), "power-up pulse");
	endtask : start
	// unkicked run: long first period, flag, kick during pulse, pulse length
	task t_mode(input logic s, t, c, e, input int r, f);
		start(s, t, c, e, r);
		wt(1'h0, f + 32);
		chk(near(f) && wdo_n === 1'h0, "first timeout");
		@(posedge clk);
		en <= 1'h1;
		repeat (4) @(posedge clk);
		en <= 1'h0;
		#1;
		chk(wdo_n === 1'h1, "flag stuck low");
		wt(1'h1, r + 32);
		chk(near(r - 5), "pulse length");
	endtask : t_mode
	task t_kick;
		start(1'h1, 1'h0, 1'h0, 1'h0, 200);
		@(posedge clk);
		gap <= 16'h28;
		en <= 1'h1;
		repeat (900) begin
			@(posedge clk);
			#1;
			chk(rst_n === 1'h1, "reset despite kicks");
		end
		@(posedge clk);
		en <= 1'h0;
		gap <= 16'h0;
		wt(1'h0, 200);
		chk(n >= 55 && n <= 104, "short period");
	endtask : t_kick
	// supply loss gates outputs; watchdog restarts after the supply pulse
	task t_sup;
		start(1'h1, 1'h1, 1'h0, 1'h0, 200);
		chk(ce_out_n === ce_in_n && bias === 1'h1, "ce pass");
		@(posedge clk);
		sv <= 1'h0;
		pfs <= 1'h1;
		repeat (6) @(posedge clk);
		#1;
		chk({ce_out_n, wdo_n, rst_n, rst_hi, bias} === 5'h1A, "supply gating");
		chk({batt, pf_n} === 2'h0, "battery while above battery");
		// now also below the battery: switchover must follow
		@(posedge clk);
		vbb <= 1'h1;
		repeat (4) @(posedge clk);
		#1;
		chk({batt, pf_n} === 2'h2, "battery or power-fail");
		@(posedge clk);
		sv <= 1'h1;
		pfs <= 1'h0;
		wt(1'h1, 240);
		chk(near(200) && batt === 1'h0 && pf_n === 1'h1, "supply return");
		wt(1'h0, 1640);
		chk(near(1600), "restart");
	endtask : t_sup
	initial begin
		t_sup();
		t_kick();
		t_mode(1'h1, 1'h1, 1'h0, 1'h0, 200, 1600);
		t_mode(1'h1, 1'h0, 1'h0, 1'h0, 200, 1600);
		t_mode(1'h0, 1'h0, 1'h1, 1'h0, 4096, 8192);
		t_mode(1'h0, 1'h0, 1'h0, 1'h1, 4096, 8192);
		final_report();
	end
endmodule : swd_core_tb
bind swd_core swd_checker #(.RESET_CYC(RESET_CYC)) u_chk (.CLK, .SYS_RST, .SUPPLY_VALID, .VCC_BELOW_BATT,
	.POWER_FAIL_SENSE_LOW, .WATCHDOG_KICK_IN, .CE_IN_N, .CE_OUT_N, .WATCHDOG_FLAG_N, .RESET_N, .RESET,
	.POWER_FAIL_FLAG_N, .BACKUP_SUPPLY_SELECT, .KICK_BIAS_EN);
